// ### rtl/uart14_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef UART14_MAP_VH
`define UART14_MAP_VH
`define OFS_DATA 5'h00
`define OFS_LEVEL 5'h04
`define OFS_IIR 5'h08
`define OFS_CTRL 5'h0c
`define OFS_RATE 5'h10
`define CTRL_RESET 16'h2800
`define CTRL_TXTRIG_LO 0
`define CTRL_RXTRIG_LO 2
`define CTRL_TXREQ_EN 5
`define CTRL_RXREQ_EN 6
`define CTRL_LOOPBACK 7
`define CTRL_RX_EN 11
`define CTRL_TX_EN 13
`define CTRL_CTS_EN 14
`define CTRL_RTS_EN 15
`define IIR_TX_REQ 0
`define IIR_RX_REQ 1
`define IIR_BRK 4
`define IIR_OE 5
`define IIR_FORCE_TX 6
`define OVERSAMPLE 4'hd
`define MID_SAMPLE 4'h6
`endif

// ### rtl/fourteen_oversample_uart.v
// 14x oversampling 8N1 UART with 64-byte FIFOs and AHB-Lite registers
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "uart14_map.vh"
module fourteen_oversample_uart #(
  parameter [31:0] BASE_ADDR = 32'h40014000,
  parameter RATE_W = 12,
  parameter DEPTH_LOG2 = 6
) (
  input wire hclk, // Bus clock, 125 MHz
  input wire hresetn, // Asynchronous reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready in
  output reg hreadyout, // Always ready
  output reg hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire serial_in_pin, // Serial receive line
  output reg serial_out_pin, // Serial transmit line
  input wire clear_to_send_n, // Remote can accept, active low
  output reg request_to_send_n, // We can accept, active low
  output reg tx_dma_req, // Transmit request
  output reg rx_dma_req, // Receive request
  input wire tx_dma_done, // Clears transmit request
  input wire rx_dma_done, // Clears receive request
  output reg uart_clk_on // UART clock running
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA = 4'b0100;
  localparam RX_STOP = 4'b1000;
  localparam TX_IDLE = 4'b0001;
  localparam TX_START = 4'b0010;
  localparam TX_DATA = 4'b0100;
  localparam TX_STOP = 4'b1000;

  // Receive trigger level from its select field
  function [DEPTH_LOG2:0] rx_trig;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: rx_trig = 7'h01;
        3'h1: rx_trig = 7'h04;
        3'h2: rx_trig = 7'h08;
        3'h3: rx_trig = 7'h10;
        3'h4: rx_trig = 7'h20;
        default: rx_trig = 7'h30;
      endcase
    end
  endfunction

  // Transmit trigger level from its select field
  function [DEPTH_LOG2:0] tx_trig;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: tx_trig = 7'h00;
        2'h1: tx_trig = 7'h04;
        2'h2: tx_trig = 7'h08;
        default: tx_trig = 7'h10;
      endcase
    end
  endfunction

  reg [10:0] rx_mem [0:DEPTH-1]; // byte, error, break
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
  reg [DEPTH_LOG2:0] rx_fill_count, tx_fill_count;
  reg [15:0] ctrl_reg;
  reg [RATE_W-1:0] rate_reg, rate_cnt_reg;
  reg overrun_flag, break_int_flag, tx_flag_reg, rx_flag_reg, wr_pend_reg;
  reg [4:0] wr_ofs_reg;
  reg rx_s1_reg, rx_s2_reg, cts_s1_reg, cts_s2_reg;
  reg [3:0] rx_state_reg, rx_os_reg, tx_state_reg, tx_os_reg;
  reg [2:0] rx_bit_reg, tx_bit_reg;
  reg [7:0] rx_sh_reg, tx_sh_reg;
  wire [DEPTH_LOG2:0] tx_lvl = tx_fill_count, rx_lvl = rx_fill_count;

  wire addr_ok = hsel & htrans[1] & hready &
    (haddr[31:5] == BASE_ADDR[31:5]);
  wire [4:0] ofs = haddr[4:0];
  wire rd_data = addr_ok & ~hwrite & (ofs == `OFS_DATA);
  wire rx_empty_flag = (rx_fill_count == 0);
  wire rx_pop = rd_data & ~rx_empty_flag;
  wire wr_data = wr_pend_reg & (wr_ofs_reg == `OFS_DATA);
  wire tx_push = wr_data & (tx_fill_count != DEPTH);
  wire wr_iir = wr_pend_reg & (wr_ofs_reg == `OFS_IIR);
  wire loopback = ctrl_reg[`CTRL_LOOPBACK];
  wire rx_line = loopback ? serial_out_pin : rx_s2_reg;
  wire tick = uart_clk_on & (rate_cnt_reg == rate_reg);
  wire rx_last = tick & (rx_os_reg == `OVERSAMPLE);
  wire tx_last = tick & (tx_os_reg == `OVERSAMPLE);
  wire cts_ok = ~ctrl_reg[`CTRL_CTS_EN] | loopback | ~cts_s2_reg;
  wire tx_pop = (tx_state_reg == TX_IDLE) & (tx_fill_count != 0) &
    ctrl_reg[`CTRL_TX_EN] & cts_ok;
  wire rx_done = (rx_state_reg == RX_STOP) & rx_last;
  wire frame_err = ~rx_line;
  wire is_break = frame_err & (rx_sh_reg == 8'h00);
  wire rx_full = (rx_fill_count == DEPTH);
  wire rx_push = rx_done & ~rx_full;
  wire rx_start = (rx_state_reg == RX_IDLE) & ctrl_reg[`CTRL_RX_EN] &
    ~rx_line;
  wire [10:0] rx_head = rx_mem[rx_rp_reg];
  wire [DEPTH_LOG2:0] rxt = rx_trig(ctrl_reg[`CTRL_RXTRIG_LO+2:2]);
  wire [DEPTH_LOG2:0] txt = tx_trig(ctrl_reg[`CTRL_TXTRIG_LO+1:0]);

  // Two-flop synchronisers for the serial input and clear-to-send
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      cts_s1_reg <= 1'b1;
      cts_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= serial_in_pin;
      rx_s2_reg <= rx_s1_reg;
      cts_s1_reg <= clear_to_send_n;
      cts_s2_reg <= cts_s1_reg;
    end
  end

  // Auto clock and rate divider; divider only runs while clock on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart_clk_on <= 1'b0;
      rate_cnt_reg <= {RATE_W{1'b0}};
    end else begin
      uart_clk_on <= rx_start | (rx_state_reg != RX_IDLE) |
        (tx_state_reg != TX_IDLE) | tx_push | (tx_fill_count != 0);
      if (!uart_clk_on || tick)
        rate_cnt_reg <= {RATE_W{1'b0}};
      else
        rate_cnt_reg <= rate_cnt_reg + 1'b1;
    end
  end

  // Receiver: qualify start at mid, then sample every 14 ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_os_reg <= 4'h0;
          rx_bit_reg <= 3'h0;
          if (rx_start)
            rx_state_reg <= RX_START;
        end
        RX_START: begin
          if (tick && rx_os_reg == `MID_SAMPLE) begin
            rx_os_reg <= 4'h0;
            if (rx_line)
              rx_state_reg <= RX_IDLE;
            else
              rx_state_reg <= RX_DATA;
          end else if (tick) begin
            rx_os_reg <= rx_os_reg + 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_last) begin
            rx_os_reg <= 4'h0;
            rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == 3'h7)
              rx_state_reg <= RX_STOP;
          end else if (tick) begin
            rx_os_reg <= rx_os_reg + 1'b1;
          end
        end
        RX_STOP: begin
          if (rx_last)
            rx_state_reg <= RX_IDLE;
          else if (tick)
            rx_os_reg <= rx_os_reg + 1'b1;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Transmitter: start, eight data bits lsb first, one stop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      serial_out_pin <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          serial_out_pin <= 1'b1;
          tx_os_reg <= 4'h0;
          tx_bit_reg <= 3'h0;
          if (tx_pop) begin
            tx_sh_reg <= tx_mem[tx_rp_reg];
            tx_state_reg <= TX_START;
          end
        end
        TX_START: begin
          serial_out_pin <= 1'b0;
          if (tx_last) begin
            tx_os_reg <= 4'h0;
            tx_state_reg <= TX_DATA;
          end else if (tick) begin
            tx_os_reg <= tx_os_reg + 1'b1;
          end
        end
        TX_DATA: begin
          serial_out_pin <= tx_sh_reg[0];
          if (tx_last) begin
            tx_os_reg <= 4'h0;
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == 3'h7)
              tx_state_reg <= TX_STOP;
          end else if (tick) begin
            tx_os_reg <= tx_os_reg + 1'b1;
          end
        end
        TX_STOP: begin
          serial_out_pin <= 1'b1;
          if (tx_last)
            tx_state_reg <= TX_IDLE;
          else if (tick)
            tx_os_reg <= tx_os_reg + 1'b1;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // FIFO storage
  always @(posedge hclk) begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= hwdata[7:0];
    if (rx_push)
      rx_mem[rx_wp_reg] <= {is_break, frame_err, 1'b0, rx_sh_reg};
  end
  // FIFO pointers and fill counts
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_reg <= {DEPTH_LOG2{1'b0}};
      tx_rp_reg <= {DEPTH_LOG2{1'b0}};
      rx_wp_reg <= {DEPTH_LOG2{1'b0}};
      rx_rp_reg <= {DEPTH_LOG2{1'b0}};
      tx_fill_count <= {(DEPTH_LOG2+1){1'b0}};
      rx_fill_count <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + 1'b1;
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + 1'b1;
      if (rx_push)
        rx_wp_reg <= rx_wp_reg + 1'b1;
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 1'b1;
      tx_fill_count <= tx_fill_count + {{DEPTH_LOG2{1'b0}}, tx_push} -
        {{DEPTH_LOG2{1'b0}}, tx_pop};
      rx_fill_count <= rx_fill_count + {{DEPTH_LOG2{1'b0}}, rx_push} -
        {{DEPTH_LOG2{1'b0}}, rx_pop};
    end
  end

  // Status flags, DMA requests and request-to-send; set beats clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_flag <= 1'b0;
      break_int_flag <= 1'b0;
      tx_flag_reg <= 1'b0;
      rx_flag_reg <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      request_to_send_n <= 1'b1;
    end else begin
      if (rx_done && rx_full)
        overrun_flag <= 1'b1;
      else if (wr_iir && hwdata[`IIR_OE])
        overrun_flag <= 1'b0;
      if (rx_push && is_break)
        break_int_flag <= 1'b1;
      else if (wr_iir && hwdata[`IIR_BRK])
        break_int_flag <= 1'b0;
      if ((tx_lvl <= txt) || (wr_iir && hwdata[`IIR_FORCE_TX]))
        tx_flag_reg <= 1'b1;
      else if (tx_dma_done)
        tx_flag_reg <= 1'b0;
      if (rx_lvl >= rxt)
        rx_flag_reg <= 1'b1;
      else if (rx_dma_done)
        rx_flag_reg <= 1'b0;
      tx_dma_req <= tx_flag_reg & ctrl_reg[`CTRL_TXREQ_EN];
      rx_dma_req <= rx_flag_reg & ctrl_reg[`CTRL_RXREQ_EN];
      request_to_send_n <= ctrl_reg[`CTRL_RTS_EN] & (rx_lvl >= rxt);
    end
  end

  // Bus slave: read data captured in address phase, writes in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 5'h00;
      ctrl_reg <= `CTRL_RESET;
      rate_reg <= {RATE_W{1'b0}};
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_ok & hwrite;
      wr_ofs_reg <= ofs;
      if (wr_pend_reg && wr_ofs_reg == `OFS_CTRL)
        ctrl_reg <= hwdata[15:0];
      if (wr_pend_reg && wr_ofs_reg == `OFS_RATE)
        rate_reg <= hwdata[RATE_W-1:0];
      if (addr_ok && !hwrite) begin
        case (ofs)
          `OFS_DATA:
            hrdata <= {21'h000000, rx_empty_flag ? 11'h100 :
              {rx_head[10:9], 1'b0, rx_head[7:0]}};
          `OFS_LEVEL:
            hrdata <= {16'h0000, 1'b0, tx_fill_count,
              1'b0, rx_fill_count};
          `OFS_IIR:
            hrdata <= {26'h0000000, overrun_flag, break_int_flag,
              2'b00, rx_flag_reg, tx_flag_reg};
          `OFS_CTRL: hrdata <= {16'h0000, ctrl_reg};
          `OFS_RATE: hrdata <= {{(32-RATE_W){1'b0}}, rate_reg};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ### dv/uart14_monitor.sv
// Port-level checks for the 14x oversampling UART
`timescale 1ns/1ps
module uart14_monitor (
  input wire hclk, // Bus clock
  input wire hresetn, // Reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire hready, // Bus ready in
  input wire hreadyout, // Bus ready out
  input wire hresp, // Bus response
  input wire [31:0] hrdata, // Read data
  input wire serial_out_pin, // Transmit line
  input wire uart_clk_on // UART clock enable
);
  reg [4:0] run_reg;
  reg last_reg;
  reg rd0_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transmit line run length, saturating; receive-port read in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 5'h00;
      last_reg <= 1'b1;
      rd0_reg <= 1'b0;
    end else begin
      rd0_reg <= hsel & htrans[1] & hready & !hwrite & (haddr[4:0] == 5'h00);
      last_reg <= serial_out_pin;
      run_reg <= (serial_out_pin != last_reg) ? 5'h00 :
        run_reg + {4'h0, run_reg != 5'h1f};
    end
  end
  // A bit lasts at least fourteen ticks of one cycle each
  chk_bit_length: assert property (
    (serial_out_pin != last_reg) |-> run_reg >= 5'h0d)
    else $error("transmit bit shorter than fourteen cycles");
  chk_idle_high: assert property (
    !uart_clk_on |-> serial_out_pin)
    else $error("transmit line low with clock off");
  chk_start_clock: assert property (
    $fell(serial_out_pin) |-> uart_clk_on)
    else $error("start bit without clock enable");
  chk_line_gated: assert property (
    (serial_out_pin != last_reg) |-> $past(uart_clk_on))
    else $error("transmit line moved while gated");
  chk_ready_always: assert property (
    hreadyout) else $error("bus wait state inserted");
  chk_resp_okay: assert property (
    !hresp) else $error("bus response not okay");
  chk_word_upper: assert property (
    rd0_reg |-> hrdata[31:11] == 21'h0)
    else $error("read data upper bits set");
  chk_empty_zero: assert property (
    rd0_reg && hrdata[8] |-> hrdata[10:0] == 11'h100)
    else $error("empty read carries data");
endmodule
bind fourteen_oversample_uart uart14_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .serial_out_pin(serial_out_pin),
  .uart_clk_on(uart_clk_on));

// ### dv/serial_peer.sv
// Remote serial device that sends and captures 8N1 frames
`timescale 1ns/1ps
module serial_peer #(
  parameter BIT_CYC = 14
) (
  input wire hclk, // Bus clock
  input wire line_in, // Frames from the UART
  output reg line_out, // Frames to the UART, idles high
  output reg cts_n // Ready to accept, active low
);
  integer i;
  reg [9:0] f;
  // Idle line, ready to accept
  initial begin
    line_out = 1'b1;
    cts_n = 1'b0;
  end
  // Start bit, data LSB first, chosen stop level
  task send(input [7:0] b, input stop);
    begin
      f = {stop, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        line_out <= f[i];
        repeat (BIT_CYC) @(posedge hclk);
      end
      line_out <= 1'b1;
    end
  endtask
  // Wait for a start bit, then sample each bit at its middle
  task get(output [7:0] b, output stop);
    begin
      for (i = 0; i < 4000 && line_in !== 1'b0; i = i + 1)
        @(posedge hclk);
      repeat (BIT_CYC / 2) @(posedge hclk);
      for (i = 0; i < 9; i = i + 1) begin
        repeat (BIT_CYC) @(posedge hclk);
        f[i] = line_in;
      end
      b = f[7:0];
      stop = f[8];
    end
  endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the 14x oversampling UART
`timescale 1ns/1ps
`include "uart14_map.vh"
module tb;
  reg hclk, hresetn, hsel, hwrite, rx_done, tx_done, s;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, v;
  reg [7:0] b;
  wire hreadyout, hresp, sout, sin, cts_n, rts_n, txq, rxq;
  wire [31:0] hrdata;
  integer failures, compares, i;
  fourteen_oversample_uart DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_in_pin(sin), .serial_out_pin(sout),
    .clear_to_send_n(cts_n), .request_to_send_n(rts_n),
    .tx_dma_req(txq), .rx_dma_req(rxq), .tx_dma_done(tx_done),
    .rx_dma_done(rx_done), .uart_clk_on());
  serial_peer peer (.hclk(hclk), .line_in(sout), .line_out(sin),
    .cts_n(cts_n));
  // Compare and count
  task check(input string n, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  // One single AHB-Lite transfer; read data lands in v
  task bus(input w, input [4:0] a, input [31:0] wd);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= 32'h40014000 | {27'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      v = hrdata;
    end
  endtask
  task rd(input [4:0] a, input string n, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(n, v, e);
    end
  endtask
  task t_reset;
    begin
      rd(`OFS_CTRL, "ctrl", 32'h2800);
      rd(`OFS_LEVEL, "level", 32'h0);
      rd(`OFS_RATE, "rate", 32'h0);
      bus(1'b1, `OFS_RATE, 32'hfffe87);
      rd(`OFS_RATE, "rate rw", 32'he87);
      bus(1'b1, `OFS_RATE, 32'h0);
      rd(`OFS_IIR, "iir", 32'h1);
      rd(`OFS_DATA, "rx empty", 32'h100);
      rd(5'h14, "unmapped", 32'h0);
      $display("reset test done");
    end
  endtask
  task t_loop;
    begin
      bus(1'b1, `OFS_CTRL, 32'h2880);
      bus(1'b1, `OFS_DATA, 32'h3c);
      bus(1'b1, `OFS_DATA, 32'hc3);
      for (i = 0; i < 400 && v !== 32'h2; i = i + 1)
        bus(1'b0, `OFS_LEVEL, 32'h0);
      check("rx level", v, 32'h2);
      rd(`OFS_DATA, "loop first", 32'h3c);
      rd(`OFS_DATA, "loop second", 32'hc3);
      bus(1'b1, `OFS_CTRL, 32'h2800);
      $display("loopback test done");
    end
  endtask
  task t_rx;
    begin
      bus(1'b1, `OFS_CTRL, 32'ha840);
      peer.send(8'h5a, 1'b1);
      repeat (3) @(posedge hclk);
      check("rx req", rxq, 32'h1);
      check("rts", rts_n, 32'h1);
      rd(`OFS_DATA, "rx byte", 32'h5a);
      rx_done <= 1'b1;
      @(posedge hclk);
      rx_done <= 1'b0;
      repeat (3) @(posedge hclk);
      check("rx req off", rxq, 32'h0);
      check("rts off", rts_n, 32'h0);
      peer.send(8'h00, 1'b0);
      repeat (3) @(posedge hclk);
      rd(`OFS_IIR, "iir brk", 32'h13);
      rd(`OFS_DATA, "brk word", 32'h600);
      bus(1'b1, `OFS_IIR, 32'h10);
      rd(`OFS_IIR, "iir clr", 32'h3);
      bus(1'b1, `OFS_CTRL, 32'h2800);
      $display("receive test done");
    end
  endtask
  task t_cts;
    begin
      bus(1'b1, `OFS_CTRL, 32'h6800);
      peer.cts_n <= 1'b1;
      bus(1'b1, `OFS_DATA, 32'h1e);
      repeat (100) @(posedge hclk);
      check("held line", sout, 32'h1);
      peer.cts_n <= 1'b0;
      peer.get(b, s);
      check("tx byte", b, 32'h1e);
      check("tx stop", s, 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h2800);
      $display("transmit test done");
    end
  endtask
  task t_ovr;
    begin
      bus(1'b1, `OFS_CTRL, 32'h2880);
      for (i = 0; i < 64; i = i + 1)
        bus(1'b1, `OFS_DATA, i);
      for (i = 0; i < 6000 && v !== 32'h40; i = i + 1)
        bus(1'b0, `OFS_LEVEL, 32'h0);
      check("rx full level", v, 32'h40);
      bus(1'b1, `OFS_DATA, 32'h77);
      repeat (200) @(posedge hclk);
      rd(`OFS_IIR, "iir overrun", 32'h23);
      rd(`OFS_LEVEL, "level kept", 32'h40);
      for (i = 0; i < 64; i = i + 1)
        rd(`OFS_DATA, "rx order", i);
      bus(1'b1, `OFS_IIR, 32'h20);
      rd(`OFS_IIR, "iir oe clr", 32'h3);
      bus(1'b1, `OFS_CTRL, 32'h2800);
      $display("overrun test done");
    end
  endtask
  task t_dma;
    begin
      bus(1'b1, `OFS_CTRL, 32'h0821);
      repeat (2) @(posedge hclk);
      check("tx req low fill", txq, 32'h1);
      for (i = 0; i < 8; i = i + 1)
        bus(1'b1, `OFS_DATA, 32'h55);
      tx_done <= 1'b1;
      @(posedge hclk);
      tx_done <= 1'b0;
      repeat (3) @(posedge hclk);
      check("tx req done", txq, 32'h0);
      rd(`OFS_LEVEL, "tx level", 32'h800);
      bus(1'b1, `OFS_IIR, 32'h40);
      repeat (2) @(posedge hclk);
      check("tx req forced", txq, 32'h1);
      rd(`OFS_IIR, "iir forced", 32'h3);
      $display("dma test done");
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Bus clock, 8 ns period
  always #4 hclk = ~hclk;
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rx_done = 1'b0;
    tx_done = 1'b0;
    failures = 0;
    compares = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_loop;
    t_rx;
    t_cts;
    t_ovr;
    t_dma;
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge hclk);
    failures = failures + 1;
    report_and_stop;
  end
endmodule
